//--- verilog/reset_park_pkg.sv
// Constants and state types of the reset, park and strap control block
`default_nettype none
package reset_park_pkg;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int STRAP_DELAY_NS  = 1500;
  // Rounded down so the sample lands no later than the nominal delay
  localparam int STRAP_DELAY_CYC = (STRAP_DELAY_NS * 1000) / CLK_PERIOD_PS;
  localparam int CNT_W           = 9;
  localparam logic [CNT_W-1:0] STRAP_LAST =
    CNT_W'(STRAP_DELAY_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO   = 9'h000;

  // ****************************************************
  // Widths and reset values
  // ****************************************************
  localparam int STRAP_W = 8;
  localparam logic [STRAP_W-1:0] STRAP_NONE   = 8'h00;
  localparam logic [STRAP_W-1:0] STRAP_ALL_ON = 8'hff;
  // Synchroniser reset values: reset held low, park request idle high
  localparam logic [1:0] SYNC_RESET_VAL = 2'h2;
  localparam int SYNC_POR  = 0;
  localparam int SYNC_PARK = 1;

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [1:0] {
    HELD,
    STRAP_WAIT,
    RUNNING
  } seq_state_t;

  // Whole state of the control block
  typedef struct packed {
    seq_state_t             seq;
    logic [CNT_W-1:0]       count;
    logic [STRAP_W-1:0]     strap_mode;
    logic                   config_start;
    logic                   park;
    logic                   por_prev;
    logic [STRAP_W-1:0]     strap_out;
    logic [STRAP_W-1:0]     strap_oe;
  } ctrl_state_t;

  // Status toward the core
  typedef struct packed {
    logic                   config_start;
    logic                   configuring;
    logic                   running;
    logic                   park_mirrors;
    logic                   test_mode;
    logic [STRAP_W-1:0]     strap_mode;
  } ctrl_status_t;

endpackage : reset_park_pkg
`default_nettype wire

//--- verilog/level_sync.sv
// Two flip-flop level synchroniser with a constant reset value
`default_nettype none
module level_sync #(
  parameter int              W         = 1,
  parameter logic [W-1:0]    RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Levels
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  // Both stages as one state word
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] out;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // ****************************************************
  // Two stages; first stage feeds only the second
  // ****************************************************
  always_comb
  begin
    next_st.meta = din;
    next_st.out  = st.meta;
  end

  // Stage registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st.meta <= RESET_VAL;
      st.out  <= RESET_VAL;
    end
    else
      st <= next_st;
  end

  // Only the second stage leaves the module
  assign dout = st.out;

endmodule : level_sync
`default_nettype wire

//--- verilog/reset_park_test_strap_control.sv
// Power-on reset, fast park and test strap control of the display controller
//
// Contract
// R1: A low fast-park request drives the mirror array park command at once; the code sets it about three clock cycles later, through the synchroniser.
// R2: The power chip asserts fast park only when a normal park cannot finish.
// R3: A rising edge of the power-on reset input starts self-configuration.
// R4: The power chip keeps power-on reset low until supplies and clocks settle.
// R5: While power-on reset is low no output is in its active state.
// R6: While power-on reset is low the eight strap pins are not driven.
// R7: About 1.5 us after reset release the straps are sampled, then driven.
// R8: A strap sampled high selects a test mode; low straps mean normal use.
// R9: The manufacturing test enable input is held low in normal use.
// R10: The internal scan reset input is held low in normal use.
// R11: The other internal scan pins are left unconnected by the far side.
// R12: Reset release and fast park are synchronised before they are used.
`default_nettype none
module reset_park_test_strap_control
  import reset_park_pkg::*;
(
  // Clock and device reset
  input  wire logic               ref_clk,
  input  wire logic               reset_n,
  // Power management side
  input  wire logic               power_on_reset_n,
  input  wire logic               fast_park_request_n,
  // Manufacturing and internal scan pins
  input  wire logic               manufacturing_test_enable,
  input  wire logic               internal_scan_reset_n,
  input  wire logic               internal_scan_clock,
  input  wire logic               internal_scan_data_in,
  input  wire logic               internal_scan_select_a,
  input  wire logic               internal_scan_select_b,
  output var  logic               internal_scan_data_out_a,
  output var  logic               internal_scan_data_out_b,
  // Test strap pins, three signals each
  input  wire logic [STRAP_W-1:0] test_strap_in,
  output var  logic [STRAP_W-1:0] test_strap_out,
  output var  logic [STRAP_W-1:0] test_strap_oe,
  // Status toward the core
  output var  ctrl_status_t       status
);

  // ****************************************************
  // Signals
  // ****************************************************
  logic        rst_sync_n;
  logic [1:0]  pins_sync;
  // Synchronised pins and the events taken from them
  logic        por_s;
  logic        park_s;
  logic        por_rise;
  logic        park_req;
  logic        strap_due;
  ctrl_state_t st;
  ctrl_state_t next_st;

  // ****************************************************
  // Decoding helpers
  // ****************************************************
  // Last cycle of the strap settling delay
  function automatic logic strap_sample_due(
    input logic [CNT_W-1:0] cnt
  );
    return cnt == STRAP_LAST;
  endfunction : strap_sample_due

  // Any strap seen high selects a test mode
  function automatic logic strap_selects_test(
    input logic [STRAP_W-1:0] straps
  );
    return straps != STRAP_NONE;
  endfunction : strap_selects_test

  // Held state: sequence idle, park cleared, straps released
  function automatic ctrl_state_t quiet_state();
    ctrl_state_t q;
    q.seq          = HELD;
    q.count        = CNT_ZERO;
    q.strap_mode   = STRAP_NONE;
    q.config_start = 1'b0;
    q.park         = 1'b0;
    q.por_prev     = 1'b0;
    q.strap_out    = STRAP_NONE;
    q.strap_oe     = STRAP_NONE; // R6
    return q;
  endfunction : quiet_state

  // ****************************************************
  // Synchronisers
  // ****************************************************
  // Device reset: asserted at once, released through two flops
  level_sync #(
    .W         (1),
    .RESET_VAL (1'b0)
  ) u_rst_sync (
    .clk   (ref_clk),
    .rst_n (reset_n),
    .din   (1'b1),
    .dout  (rst_sync_n)
  );

  // Reset and park pins brought into the clock domain
  level_sync #(
    .W         (2),
    .RESET_VAL (SYNC_RESET_VAL)
  ) u_pin_sync (
    .clk   (ref_clk),
    .rst_n (rst_sync_n),
    .din   ({fast_park_request_n, power_on_reset_n}),
    .dout  (pins_sync)
  ); // R12

  // Synchronised pin levels
  assign por_s  = pins_sync[SYNC_POR];
  assign park_s = pins_sync[SYNC_PARK];

  // ****************************************************
  // Pin events
  // ****************************************************
  // Release is a high sample after a low one
  assign por_rise  = por_s && !st.por_prev; // R3
  // Park pin is active low
  assign park_req  = !park_s; // R1
  // Straps settled long enough to be read
  assign strap_due = strap_sample_due(st.count); // R7

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb
  begin
    next_st              = st;
    next_st.config_start = 1'b0;
    next_st.por_prev     = por_s;
    // Park is latched until the next power-on reset
    if (park_req)
      next_st.park = 1'b1; // R1
    if (!por_s)
    begin
      // Everything quiet and straps released while reset is low
      next_st = quiet_state(); // R5 R6
    end
    else
    begin
      unique case (st.seq)
        HELD:
        begin
          // Wait for the release edge of the reset pin
          if (por_rise)
          begin
            next_st.seq          = STRAP_WAIT;
            next_st.config_start = 1'b1; // R3
            next_st.count        = CNT_ZERO;
          end
        end
        STRAP_WAIT:
        begin
          // Count out the strap settling delay
          if (strap_due)
          begin
            // Sample straps, then turn them around to outputs
            next_st.seq        = RUNNING;
            next_st.strap_mode = test_strap_in; // R7
            next_st.strap_oe   = STRAP_ALL_ON; // R7
          end
          else
            next_st.count = st.count + 1'b1;
        end
        RUNNING:
        begin
          // Straps echo the selected mode as test observation
          next_st.strap_out = st.strap_mode;
        end
      endcase
    end
  end

  // ****************************************************
  // State register
  // ****************************************************
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      // Quiet state on device reset
      st.seq          <= HELD;
      st.count        <= CNT_ZERO;
      st.strap_mode   <= STRAP_NONE;
      st.config_start <= 1'b0;
      st.park         <= 1'b0;
      st.por_prev     <= 1'b0;
      st.strap_out    <= STRAP_NONE;
      st.strap_oe     <= STRAP_NONE;
    end
    else
      st <= next_st;
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  always_comb
  begin
    status.config_start = st.config_start;
    status.configuring  = (st.seq == STRAP_WAIT);
    status.running      = (st.seq == RUNNING);
    status.park_mirrors = st.park;
    // Any strap high selects a test mode
    status.test_mode    = strap_selects_test(st.strap_mode); // R8
    status.strap_mode   = st.strap_mode;
  end

  // ****************************************************
  // Pin outputs
  // ****************************************************
  // Strap pins carry the registered drive and enable
  assign test_strap_out           = st.strap_out; // R7
  assign test_strap_oe            = st.strap_oe; // R6
  // Scan chain is not implemented; its outputs idle low
  assign internal_scan_data_out_a = 1'b0; // R5
  assign internal_scan_data_out_b = 1'b0; // R5

endmodule : reset_park_test_strap_control
`default_nettype wire

//--- dv/reset_park_monitor.sv
// Assertions on the ports of the reset, park and strap control block
`default_nettype none
module reset_park_monitor
  import reset_park_pkg::*;
(
  // Clock and reset
  input wire logic               ref_clk,
  input wire logic               reset_n,
  // Pins and status
  input wire logic               power_on_reset_n,
  input wire logic               fast_park_request_n,
  input wire logic [STRAP_W-1:0] test_strap_in,
  input wire logic [STRAP_W-1:0] test_strap_out,
  input wire logic [STRAP_W-1:0] test_strap_oe,
  input wire ctrl_status_t       status
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Start and strap timing
  AST_CFG: assert property (
    $rose(power_on_reset_n) |-> ##[3:4] status.config_start
  ) else $error("config start late");
  AST_WAIT: assert property (
    status.config_start |-> ##[374:374] !status.running ##1 status.running
  ) else $error("strap sample time wrong");
  // Quiet while reset pin is low
  AST_HELD: assert property (
    (!power_on_reset_n)[*6] |-> !status.running && !status.configuring
      && !status.park_mirrors && test_strap_out == STRAP_NONE
  ) else $error("output active in reset");
  AST_HIZ: assert property (
    (!power_on_reset_n)[*6] |-> test_strap_oe == STRAP_NONE
  ) else $error("strap driven in reset");
  // Strap sampling and driving, and park latency
  AST_DRIVE: assert property (
    status.running |-> test_strap_oe == STRAP_ALL_ON
  ) else $error("strap not driven");
  AST_SAMPLE: assert property (
    $rose(status.running) |-> status.strap_mode == $past(test_strap_in)
      && status.test_mode == (|$past(test_strap_in))
  ) else $error("strap sample wrong");
  AST_ECHO: assert property (
    status.running && $past(status.running) |->
      test_strap_out == status.strap_mode
  ) else $error("strap output wrong");
  AST_PARK: assert property (
    (status.configuring || status.running) && $fell(fast_park_request_n)
      |-> ##[3:4] status.park_mirrors
  ) else $error("park late");
  // Main scenarios
  cover property (status.config_start);
  cover property ($rose(status.running) && status.test_mode);
  cover property ($rose(status.park_mirrors));
endmodule : reset_park_monitor
`default_nettype wire

//--- dv/power_chip_model.sv
// Power chip model driving power-on reset and fast park
`default_nettype none
module power_chip_model (
  // Clock and commands
  input  wire logic ref_clk,
  input  wire logic por_cmd,
  input  wire logic park_cmd,
  // Pins toward the controller
  output var  logic power_on_reset_n,
  output var  logic fast_park_request_n,
  output var  logic manufacturing_test_enable,
  output var  logic internal_scan_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int settle = 0;
  // Supplies and clocks settle after eight edges
  always @(posedge ref_clk)
    if (settle < 8) settle <= settle + 1;
  // Pin levels
  assign power_on_reset_n = por_cmd && settle == 8;
  assign fast_park_request_n = !park_cmd;
  assign manufacturing_test_enable = 1'b0;
  assign internal_scan_reset_n = 1'b0;
endmodule : power_chip_model
`default_nettype wire

//--- dv/reset_park_test_strap_control_tb_top.sv
// Self-checking bench of the reset, park and strap control block
`default_nettype none
module reset_park_test_strap_control_tb_top
  import reset_park_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic               ref_clk = 0;
  logic               reset_n = 0;
  logic               por_cmd = 0;
  logic               park_cmd = 0;
  logic               por_n, park_n, mte, scan_rst_n;
  logic               scan_a, scan_b;
  logic [STRAP_W-1:0] pull = '0;
  logic [STRAP_W-1:0] pin_in, pin_out, pin_oe;
  logic [31:0]        seed = 32'h7a4e_3531;
  logic [7:0]         exp_q[$];
  ctrl_status_t       status;
  int                 mismatches = 0;
  int                 tests_run = 0;
  int                 n;
  // Clock and strap wire level
  always #2 ref_clk = ~ref_clk;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pull);
  power_chip_model u_pwr (.ref_clk, .por_cmd, .park_cmd,
    .power_on_reset_n (por_n), .fast_park_request_n (park_n),
    .manufacturing_test_enable (mte), .internal_scan_reset_n (scan_rst_n));
  reset_park_test_strap_control u_dut (.ref_clk, .reset_n,
    .power_on_reset_n (por_n), .fast_park_request_n (park_n),
    .manufacturing_test_enable (mte), .internal_scan_reset_n (scan_rst_n),
    .internal_scan_clock (1'bz), .internal_scan_data_in (1'bz),
    .internal_scan_select_a (1'bz), .internal_scan_select_b (1'bz),
    .internal_scan_data_out_a (scan_a), .internal_scan_data_out_b (scan_b),
    .test_strap_in (pin_in), .test_strap_out (pin_out),
    .test_strap_oe (pin_oe), .status);
  // Compare and count
  task automatic check(input logic [31:0] seen, exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Next value of the xorshift generator
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xorshift
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // Bounded wait for one status bit
  task automatic wait_bit(input int b, input int lim);
    n = 0;
    while (status[b] !== 1'b1 && n < lim)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (status[b] !== 1'b1)
    begin
      mismatches++;
      test_done();
    end
  endtask : wait_bit
  // Main sequence
  initial
  begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (12) @(posedge ref_clk);
    park_cmd <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1 check(status.park_mirrors, 0, "park in reset");
    check(pin_oe, 0, "oe in reset");
    check({scan_a, scan_b}, 0, "scan outputs");
    $display("test held done");
    for (int i = 0; i < 4; i++)
    begin
      seed = xorshift(seed);
      exp_q.push_back(i == 0 ? 8'h00 : i == 1 ? 8'hff : seed[7:0]);
      @(posedge ref_clk);
      park_cmd <= 1'b0;
      pull <= exp_q[0];
      @(posedge ref_clk);
      por_cmd <= 1'b1;
      wait_bit(12, 8);
      check(n >= 3 && n <= 4, 1, "config latency");
      check(status.configuring, 1, "configuring");
      wait_bit(10, 400);
      check(n, 375, "strap delay");
      check(status.strap_mode, exp_q[0], "strap mode");
      check(status.test_mode, |exp_q[0], "test mode");
      check(pin_oe, STRAP_ALL_ON, "strap oe");
      @(posedge ref_clk);
      park_cmd <= i[0];
      #1 check(pin_out, exp_q.pop_front(), "strap out");
      if (i[0])
      begin
        wait_bit(9, 6);
        check(n >= 2 && n <= 3, 1, "park latency");
      end
      @(posedge ref_clk);
      por_cmd <= 1'b0;
      repeat (8) @(posedge ref_clk);
      #1 check(status.park_mirrors, 0, "park cleared");
      check(pin_oe | pin_out, 0, "strap idle");
      $display("test cycle %0d done", i);
    end
    test_done();
  end
endmodule : reset_park_test_strap_control_tb_top
bind reset_park_test_strap_control reset_park_monitor u_mon (.ref_clk,
  .reset_n, .power_on_reset_n, .fast_park_request_n, .test_strap_in,
  .test_strap_out, .test_strap_oe, .status);
`default_nettype wire
